//--- pkg/sccr_pkg.sv
`default_nettype none
package sccr_pkg;

    // Data path width and serial clock half period in sys_clk cycles
    localparam int unsigned SCCR_W        = 16;
    localparam int unsigned SCCR_HALF_CYC = 4;
    localparam logic [2:0]  SCCR_DIV_LAST = 3'(SCCR_HALF_CYC - 1);

    // Command/response frame layout
    localparam logic [4:0]  SCCR_CMD_BITS   = 5'h08;
    localparam logic [4:0]  SCCR_CMD_LAST   = 5'h07;
    localparam logic [4:0]  SCCR_RESP_FIRST = 5'h09;
    localparam logic [3:0]  SCCR_SIZE_MIN   = 4'h3;
    localparam logic [15:0] SCCR_ZERO       = 16'h0000;
    localparam logic [7:0]  SCCR_ZERO8      = 8'h00;

    // Bit positions inside the synchroniser vector
    localparam int unsigned SCCR_SY_SCLK = 0;
    localparam int unsigned SCCR_SY_CS   = 1;
    localparam int unsigned SCCR_SY_DIN  = 2;
    localparam int unsigned SCCR_SY_SDI  = 3;
    localparam int unsigned SCCR_SY_W    = 4;

    typedef enum logic [2:0] {
        SCCR_IDLE  = 3'b000,
        SCCR_SETUP = 3'b001,
        SCCR_SHIFT = 3'b010,
        SCCR_TAIL  = 3'b011,
        SCCR_SLAVE = 3'b100
    } sccr_state_e;

endpackage
`default_nettype wire

//--- src/sccr_sync.sv
`timescale 1ns/1ps
`default_nettype none
module sccr_sync
#(
    parameter int unsigned W = 4
)
(
    input  wire logic         sys_clk,  // System clock
    input  wire logic         reset_n,  // Asynchronous reset, active low
    input  wire logic [W-1:0] async_in, // Inputs from outside the clock domain
    output logic      [W-1:0] sync_out  // Synchronised copies
);
    logic [W-1:0] meta_q;

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            meta_q   <= '0;
            sync_out <= '0;
        end
        else
        begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule // sccr_sync
`default_nettype wire

//--- src/sccr_frame_engine.sv
`timescale 1ns/1ps
`default_nettype none
module sccr_frame_engine
    import sccr_pkg::*;
(
    input  wire logic        sys_clk,                 // 125 MHz clock
    input  wire logic        reset_n,                 // Asynchronous reset, active low
    input  wire logic        enable,                  // Port enable
    input  wire logic        master_mode,             // 1 master, 0 slave
    input  wire logic        cmd_resp_mode,           // 1 command/response, 0 plain serial
    input  wire logic        clock_polarity_bit,      // Idle level of the clock
    input  wire logic        clock_phase_bit,         // Capture edge select
    input  wire logic [3:0]  data_size,               // Word length minus one
    input  wire logic        tx_valid,                // Transmit FIFO has a word
    input  wire logic [15:0] tx_data,                 // Transmit FIFO oldest word
    output logic             tx_ready,                // Word taken from transmit FIFO
    output logic             rx_valid,                // Received word pulse
    output logic      [15:0] rx_data,                 // Received word
    output logic             serial_clock_line_o,     // Clock drive
    output logic             serial_clock_line_oe_n,  // Clock enable, low drives
    input  wire logic        serial_clock_line_i,     // Clock pin level
    output logic             sel_n_o,                 // Chip select drive
    output logic             sel_n_oe_n,              // Chip select enable, low drives
    input  wire logic        sel_n_i,                 // Chip select pin level
    output logic             cmd_out_o,               // Master out line drive
    output logic             cmd_out_oe_n,            // Master out enable, low drives
    input  wire logic        resp_in_i,               // Master in line level
    input  wire logic        slave_in_i,              // Slave data in level
    output logic             slave_out_o,             // Slave response drive
    output logic             slave_out_oe_n           // Slave response enable, low drives
);

    function automatic logic [15:0] align_word(input logic [15:0] d, input logic [3:0] sz, input logic cr);
        align_word = cr ? {d[7:0], SCCR_ZERO8} : (d << (4'hF - sz));
    endfunction

    sccr_state_e state_q, state_d;
    logic [2:0]  div_q;
    logic        ph_q, ph_d;
    logic        cs_q, cs_d;
    logic        done_q, done_d;
    logic [4:0]  cnt_q, cnt_d;
    logic [15:0] tx_sh_q, tx_sh_d;
    logic [15:0] rx_sh_q, rx_sh_d;
    logic [15:0] rx_data_d;
    logic        rx_valid_q, rx_valid_d;
    logic        sout_q, sout_d;
    logic        sout_oe_n_q, sout_oe_n_d;
    logic        sclk_prev_q, cs_prev_q;
    logic        take;

    wire [SCCR_SY_W-1:0] sy;
    sccr_sync #(.W(SCCR_SY_W)) u_sync (
        .sys_clk  (sys_clk),
        .reset_n  (reset_n),
        .async_in ({slave_in_i, resp_in_i, sel_n_i, serial_clock_line_i}),
        .sync_out (sy)
    );

    wire        cr        = cmd_resp_mode;
    wire        clock_polarity_bit_eff  = cr ? 1'b0 : clock_polarity_bit;
    wire        clock_phase_bit_eff  = cr ? 1'b0 : clock_phase_bit;
    wire [3:0]  size_eff  = (data_size < SCCR_SIZE_MIN) ? SCCR_SIZE_MIN : data_size;
    wire [4:0]  last_cnt  = cr ? (SCCR_RESP_FIRST + {1'b0, size_eff}) : {1'b0, size_eff};
    wire        tick      = (div_q == SCCR_DIV_LAST);
    wire        cap_edge  = (~ph_q) ^ clock_phase_bit_eff;
    wire        resp_bit  = !cr || (cnt_q >= SCCR_RESP_FIRST);
    wire        shift_en  = !(clock_phase_bit_eff && (cnt_q == 5'h00));
    wire        cont_ok   = tx_valid && enable && (cr || clock_phase_bit_eff);
    wire        s_sclk    = sy[SCCR_SY_SCLK];
    wire        s_cs      = sy[SCCR_SY_CS];
    wire        s_rise    = s_sclk && !sclk_prev_q;
    wire        s_fall    = !s_sclk && sclk_prev_q;
    wire        cs_fall   = !s_cs && cs_prev_q;
    wire [15:0] m_rx_next = {rx_sh_q[14:0], sy[SCCR_SY_DIN]};
    wire [15:0] s_rx_next = {rx_sh_q[14:0], sy[SCCR_SY_SDI]};
    wire        m_active  = enable && master_mode;

    assign tx_ready               = take;
    assign rx_valid               = rx_valid_q;
    assign serial_clock_line_o    = ph_q ^ clock_polarity_bit_eff;
    assign serial_clock_line_oe_n = !m_active;
    assign sel_n_o                = cs_q;
    assign sel_n_oe_n             = !m_active;
    assign cmd_out_o              = tx_sh_q[15] && (state_q != SCCR_IDLE);
    assign cmd_out_oe_n           = !(m_active && (cr || !cs_q));
    assign slave_out_o            = sout_q;
    assign slave_out_oe_n         = sout_oe_n_q;

    always_comb
    begin
        state_d     = state_q;
        ph_d        = ph_q;
        cs_d        = cs_q;
        done_d      = done_q;
        cnt_d       = cnt_q;
        tx_sh_d     = tx_sh_q;
        rx_sh_d     = rx_sh_q;
        rx_data_d   = rx_data;
        rx_valid_d  = 1'b0;
        sout_d      = sout_q;
        sout_oe_n_d = sout_oe_n_q;
        take        = 1'b0;
        case (state_q)
            SCCR_IDLE:
            begin
                cs_d        = 1'b1;
                ph_d        = 1'b0;
                sout_oe_n_d = 1'b1;
                if (m_active && tx_valid && tick)
                begin
                    state_d = SCCR_SETUP;
                    cs_d    = 1'b0;
                    take    = 1'b1;
                    tx_sh_d = align_word(tx_data, size_eff, cr);
                    rx_sh_d = SCCR_ZERO;
                    cnt_d   = 5'h00;
                    done_d  = 1'b0;
                end
                else if (enable && !master_mode && cr && cs_fall)
                begin
                    state_d = SCCR_SLAVE;
                    take    = tx_valid;
                    tx_sh_d = tx_valid ? align_word(tx_data, size_eff, 1'b0) : SCCR_ZERO;
                    rx_sh_d = SCCR_ZERO;
                    cnt_d   = 5'h00;
                end
            end
            SCCR_SETUP:
            begin
                if (tick)
                begin
                    state_d = SCCR_SHIFT;
                end
            end
            SCCR_SHIFT:
            begin
                if (tick && cap_edge)
                begin
                    ph_d = ~ph_q;
                    if (resp_bit)
                    begin
                        rx_sh_d = m_rx_next;
                    end
                    if (cnt_q == last_cnt)
                    begin
                        done_d = 1'b1;
                    end
                    else
                    begin
                        cnt_d = cnt_q + 5'h01;
                    end
                end
                else if (tick && done_q && cont_ok)
                begin
                    ph_d       = ~ph_q;
                    take       = 1'b1;
                    tx_sh_d    = align_word(tx_data, size_eff, cr);
                    rx_sh_d    = SCCR_ZERO;
                    rx_data_d  = rx_sh_q;
                    rx_valid_d = 1'b1;
                    cnt_d      = 5'h00;
                    done_d     = 1'b0;
                end
                else if (tick && done_q)
                begin
                    state_d = SCCR_TAIL;
                    ph_d    = 1'b0;
                end
                else if (tick)
                begin
                    ph_d = ~ph_q;
                    if (shift_en)
                    begin
                        tx_sh_d = tx_sh_q << 1;
                    end
                end
            end
            SCCR_TAIL:
            begin
                if (tick)
                begin
                    state_d    = SCCR_IDLE;
                    cs_d       = 1'b1;
                    rx_data_d  = rx_sh_q;
                    rx_valid_d = 1'b1;
                end
            end
            SCCR_SLAVE:
            begin
                if (s_cs || !enable)
                begin
                    state_d     = SCCR_IDLE;
                    sout_oe_n_d = 1'b1;
                end
                else if (s_rise)
                begin
                    if (cnt_q < SCCR_CMD_BITS)
                    begin
                        rx_sh_d = s_rx_next;
                    end
                    if (cnt_q == SCCR_CMD_LAST)
                    begin
                        rx_data_d  = s_rx_next;
                        rx_valid_d = 1'b1;
                    end
                    if (cnt_q <= last_cnt)
                    begin
                        cnt_d = cnt_q + 5'h01;
                    end
                end
                else if (s_fall && (cnt_q >= SCCR_RESP_FIRST) && (cnt_q <= last_cnt))
                begin
                    sout_d      = tx_sh_q[15];
                    sout_oe_n_d = 1'b0;
                    tx_sh_d     = tx_sh_q << 1;
                end
                else if (s_fall && (cnt_q > last_cnt))
                begin
                    sout_oe_n_d = 1'b1;
                    sout_d      = 1'b0;
                    cnt_d       = 5'h00;
                    rx_sh_d     = SCCR_ZERO;
                    take        = tx_valid;
                    tx_sh_d     = tx_valid ? align_word(tx_data, size_eff, 1'b0) : SCCR_ZERO;
                end
            end
            default:
            begin
                state_d = SCCR_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            div_q <= '0;
        end
        else
        begin
            div_q <= tick ? '0 : div_q + 3'h1;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            sclk_prev_q <= 1'b0;
            cs_prev_q   <= 1'b0;  // Matches the synchroniser reset level, so no false select fall
        end
        else
        begin
            sclk_prev_q <= s_sclk;
            cs_prev_q   <= s_cs;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_q     <= SCCR_IDLE;
            ph_q        <= 1'b0;
            cs_q        <= 1'b1;
            done_q      <= 1'b0;
            cnt_q       <= '0;
            tx_sh_q     <= SCCR_ZERO;
            rx_sh_q     <= SCCR_ZERO;
            rx_data     <= SCCR_ZERO;
            rx_valid_q  <= 1'b0;
            sout_q      <= 1'b0;
            sout_oe_n_q <= 1'b1;
        end
        else
        begin
            state_q     <= state_d;
            ph_q        <= ph_d;
            cs_q        <= cs_d;
            done_q      <= done_d;
            cnt_q       <= cnt_d;
            tx_sh_q     <= tx_sh_d;
            rx_sh_q     <= rx_sh_d;
            rx_data     <= rx_data_d;
            rx_valid_q  <= rx_valid_d;
            sout_q      <= sout_d;
            sout_oe_n_q <= sout_oe_n_d;
        end
    end

endmodule // sccr_frame_engine
`default_nettype wire

//--- bench/sccr_slv_model.sv
`timescale 1ns/1ps
`default_nettype none
module sccr_slv_model
(
    input  wire logic        sclk,      // Serial clock from the port
    input  wire logic        sel_n,     // Chip select, active low
    input  wire logic        cmd_in,    // Control bits from the port
    input  wire logic [15:0] resp_word, // Word to return
    input  wire logic [3:0]  resp_size, // Response length minus one
    output logic             resp_out,  // Response line
    output logic      [7:0]  cmd_q      // Last control byte seen
);
    logic [4:0] rise_q;
    wire  [4:0] lst = 5'h0A + {1'b0, resp_size};

    initial resp_out = 1'b0;

    // Rising edges counted per frame; wraps for back-to-back frames
    always @(posedge sclk or posedge sel_n)
    begin
        if (sel_n)
            rise_q <= 5'h00;
        else
        begin
            rise_q <= (rise_q == lst) ? 5'h01 : rise_q + 5'h01;
            if (rise_q == lst || rise_q < 5'h08)
                cmd_q <= {cmd_q[6:0], cmd_in};
        end
    end

    always @(negedge sclk)
    begin
        if (rise_q >= 5'h09 && rise_q < lst)
            resp_out <= resp_word[lst - 5'h01 - rise_q];
        else
            resp_out <= ~resp_out; // Released line never holds a stale bit
    end
endmodule // sccr_slv_model
`default_nettype wire

//--- bench/sccr_frame_engine_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module sccr_chk
(
    input wire logic        sys_clk,                // Clock
    input wire logic        reset_n,                // Reset, active low
    input wire logic        enable,                 // Port enable
    input wire logic        master_mode,            // Master select
    input wire logic        cmd_resp_mode,          // Frame format
    input wire logic [15:0] tx_data,                // Transmit word
    input wire logic        tx_ready,               // Transmit pop
    input wire logic        rx_valid,               // Receive push
    input wire logic        serial_clock_line_o,    // Clock drive
    input wire logic        serial_clock_line_oe_n, // Clock enable
    input wire logic        sel_n_o,                // Select drive
    input wire logic        sel_n_oe_n,             // Select enable
    input wire logic        sel_n_i,                // Select pin
    input wire logic        cmd_out_o,              // Serial out drive
    input wire logic        cmd_out_oe_n,           // Serial out enable
    input wire logic        slave_out_oe_n          // Response enable
);
    logic       clk_q;
    logic [7:0] age_q;
    logic [7:0] low_q;
    wire        m_cr = enable & master_mode & cmd_resp_mode;

    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    // Cycles since the last rising clock edge and since select fell
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            clk_q <= 1'b0;
            age_q <= 8'h00;
            low_q <= 8'h00;
        end
        else
        begin
            clk_q <= serial_clock_line_o;
            age_q <= (serial_clock_line_o & ~clk_q) ? 8'h01 : age_q + {7'h00, age_q != 8'hFF};
            low_q <= sel_n_o ? 8'h00 : low_q + {7'h00, low_q != 8'hFF};
        end
    end

    property p_idle; m_cr && sel_n_o && $past(sel_n_o) |-> !serial_clock_line_o && !cmd_out_o; endproperty
    a_idle: assert property (p_idle) else $error("idle levels wrong");
    property p_start; m_cr && sel_n_o && tx_ready |=> !sel_n_o && cmd_out_o == $past(tx_data[7]); endproperty
    a_start: assert property (p_start) else $error("frame start wrong");
    property p_end; m_cr && $rose(sel_n_o) |-> age_q == 8'h08 && rx_valid; endproperty
    a_end: assert property (p_end) else $error("frame end timing wrong");
    property p_len; m_cr && $rose(sel_n_o) |-> low_q >= 8'h70; endproperty
    a_len: assert property (p_len) else $error("frame too short");
    property p_oe; enable && master_mode |-> !sel_n_oe_n && !serial_clock_line_oe_n && (!cmd_resp_mode || !cmd_out_oe_n);
    endproperty
    a_oe: assert property (p_oe) else $error("master drivers off");
    property p_rx; rx_valid |=> !rx_valid; endproperty
    a_rx: assert property (p_rx) else $error("receive pulse too long");
    property p_cont; m_cr && !sel_n_o && tx_ready |-> ##[0:1] rx_valid ##1 !sel_n_o [*4]; endproperty
    a_cont: assert property (p_cont) else $error("continuous frame broken");
    property p_slv; (enable && !master_mode && sel_n_i) [*6] |-> slave_out_oe_n; endproperty
    a_slv: assert property (p_slv) else $error("response line driven");
endmodule // sccr_chk

bind sccr_frame_engine sccr_chk i_chk (.sys_clk, .reset_n, .enable, .master_mode, .cmd_resp_mode, .tx_data,
    .tx_ready, .rx_valid, .serial_clock_line_o, .serial_clock_line_oe_n, .sel_n_o, .sel_n_oe_n, .sel_n_i,
    .cmd_out_o, .cmd_out_oe_n, .slave_out_oe_n);
`default_nettype wire

//--- bench/tb_serial_cmd_response_frame_engine.sv
`timescale 1ns/1ps
`default_nettype none
module tb_serial_cmd_response_frame_engine;
    localparam int LIMIT = 20000;
    logic        sys_clk = 1'b0, reset_n = 1'b0, enable = 1'b1, master_mode = 1'b1, cmd_resp_mode = 1'b1;
    logic        clock_polarity_bit = 1'b0, clock_phase_bit = 1'b0, tx_valid = 1'b0;
    logic        sk_drv = 1'b0, cs_drv = 1'b1, slave_in_i = 1'b0;
    logic [3:0]  data_size = 4'h3, m_size = 4'h3;
    logic [15:0] tx_data = 16'h0000, m_word = 16'h0000, rx_data;
    logic        tx_ready, rx_valid, serial_clock_line_o, serial_clock_line_oe_n, sel_n_o, sel_n_oe_n;
    logic        cmd_out_o, cmd_out_oe_n, resp_in_i, slave_out_o, slave_out_oe_n;
    logic [7:0]  cmd_seen;
    logic [15:0] rxq[$];
    int          error_cnt = 0, checked = 0, cyc = 0;
    wire         serial_clock_line_i = serial_clock_line_oe_n ? sk_drv : serial_clock_line_o;
    wire         sel_n_i = sel_n_oe_n ? cs_drv : sel_n_o;

    sccr_frame_engine i_dut (.sys_clk, .reset_n, .enable, .master_mode, .cmd_resp_mode, .clock_polarity_bit,
        .clock_phase_bit, .data_size, .tx_valid, .tx_data, .tx_ready, .rx_valid, .rx_data, .serial_clock_line_o,
        .serial_clock_line_oe_n, .serial_clock_line_i, .sel_n_o, .sel_n_oe_n, .sel_n_i, .cmd_out_o,
        .cmd_out_oe_n, .resp_in_i, .slave_in_i, .slave_out_o, .slave_out_oe_n);
    sccr_slv_model i_slv (.sclk(serial_clock_line_o), .sel_n(sel_n_o), .cmd_in(cmd_out_o), .resp_word(m_word),
        .resp_size(m_size), .resp_out(resp_in_i), .cmd_q(cmd_seen));

    always #4 sys_clk = ~sys_clk;

    // Collect received words and cut a hang short
    always @(posedge sys_clk)
    begin
        cyc++;
        if (rx_valid === 1'b1)
            rxq.push_back(rx_data);
        if (cyc == LIMIT)
        begin
            error_cnt++;
            conclude();
        end
    end

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("BAD t=%0t got %h want %h", $time, seen, exp);
        end
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    task automatic wait_q(input int k);
        int n;
        n = 0;
        while (rxq.size() < k && n < 2000)
        begin
            @(negedge sys_clk);
            n++;
        end
    endtask

    task automatic wait_rx(input logic [15:0] exp);
        wait_q(1);
        if (rxq.size() == 0)
            rxq.push_back(~exp);
        chk(rxq.pop_front(), exp);
    endtask

    task automatic send(input logic [15:0] d, input logic keep);
        int n;
        n = 0;
        tx_data = d;
        tx_valid = 1'b1;
        while (tx_ready !== 1'b1 && n < 400)
        begin
            @(negedge sys_clk);
            n++;
        end
        chk(16'(tx_ready), 16'h0001);
        step(1);
        tx_valid = keep;
    endtask

    task automatic t_single();
        logic [3:0] sz [4] = '{4'h3, 4'h7, 4'hF, 4'h1};
        for (int i = 0; i < 4; i++)
        begin
            data_size = sz[i];
            m_size = (sz[i] < 4'h3) ? 4'h3 : sz[i];
            m_word = 16'hB6D3 + 16'(i);
            send(16'h00C5 + 16'(i), 1'b0);
            wait_rx(m_word & (16'hFFFF >> (4'hF - m_size)));
            chk(16'(cmd_seen), 16'h00C5 + 16'(i));
            chk(16'({sel_n_o, serial_clock_line_o, cmd_out_o}), 16'h0004);
            step(8);
        end
        $display("single frames done");
    endtask

    task automatic t_cont();
        data_size = 4'h4;
        m_size = 4'h4;
        m_word = 16'h0013;
        send(16'h005A, 1'b1);
        send(16'h00E1, 1'b0);
        wait_rx(16'h0013);
        chk(16'(sel_n_o), 16'h0000);
        m_word = 16'h000C;
        wait_rx(16'h000C);
        chk(16'(cmd_seen), 16'h00E1);
        step(8);
        $display("continuous frames done");
    endtask

    task automatic t_spi();
        logic [15:0] pat;
        logic [15:0] lvl;
        cmd_resp_mode = 1'b0;
        for (int i = 0; i < 2; i++)
        begin
            clock_polarity_bit = (i == 0);
            clock_phase_bit = (i == 0);
            lvl = (i == 0) ? 16'h0003 : 16'h0002;
            step(2);
            chk(16'({sel_n_o, serial_clock_line_o}), lvl);
            // Partner line toggles on each falling edge, so its level now fixes the captured pattern
            pat = (resp_in_i ^ clock_phase_bit) ? 16'h0015 : 16'h000A;
            send(16'h00A7, 1'b0);
            wait_q(1);
            step(1);
            chk(16'({rxq.size() == 1, sel_n_o, serial_clock_line_o}), lvl | 16'h0004);
            wait_rx(pat);
            rxq.delete();
        end
        $display("plain serial frame done");
    endtask

    task automatic t_slave();
        logic [7:0]  ctl = 8'h96;
        logic [15:0] rsp = 16'h002B;
        master_mode = 1'b0;
        cmd_resp_mode = 1'b1;
        clock_polarity_bit = 1'b0;
        clock_phase_bit = 1'b0;
        data_size = 4'h5;
        tx_data = rsp;
        tx_valid = 1'b1;
        step(4);
        cs_drv = 1'b0;
        slave_in_i = ctl[7];
        step(40); // Select leads the first sampling edge by two periods
        tx_valid = 1'b0;
        for (int k = 1; k <= 15; k++)
        begin
            if (k < 10)
                chk(16'(slave_out_oe_n), 16'h0001);
            else
                chk(16'({slave_out_oe_n, slave_out_o}), 16'(rsp[15 - k]));
            sk_drv = 1'b1;
            step(10);
            sk_drv = 1'b0;
            if (k < 8)
                slave_in_i = ctl[7 - k];
            step(10);
        end
        chk(16'(slave_out_oe_n), 16'h0001);
        wait_rx(16'(ctl));
        cs_drv = 1'b1;
        step(10);
        $display("slave frame done");
    endtask

    initial
    begin
        step(16);
        reset_n = 1'b1;
        step(4);
        chk(16'({sel_n_o, serial_clock_line_o, cmd_out_o}), 16'h0004);
        t_single();
        t_cont();
        t_spi();
        t_slave();
        conclude();
    end
endmodule // tb_serial_cmd_response_frame_engine
`default_nettype wire
